/* File: include/drive_ctrl_pkg.sv */
// shared constants for the start-lock, flash-clear and fieldbus setting block
package drive_ctrl_pkg;
  // parameter addresses on the link
  localparam logic [2:0]  PAR_LOCK_ADDR     = 3'h0;
  localparam logic [2:0]  PAR_ERASE_ADDR    = 3'h1;
  localparam logic [2:0]  PAR_EXT_ADDR      = 3'h2;
  localparam logic [2:0]  PAR_PFE_ADDR      = 3'h3;
  localparam logic [2:0]  PAR_PROG_ADDR     = 3'h4;
  // parameter values
  localparam logic [15:0] LOCK_RESET        = 16'h0000;
  localparam logic [15:0] LOCK_MAX          = 16'h0001;
  localparam logic [15:0] ERASE_KEY         = 16'h25e0;
  localparam logic [15:0] ERASE_MAX         = 16'h270f;
  localparam logic [15:0] EXT_RESET         = 16'h0000;
  localparam logic [15:0] PFE_RESET         = 16'h0000;
  // extended-setting codes
  localparam logic [15:0] EXT_V1_LEGACY     = 16'h0000;
  localparam logic [15:0] EXT_V2_X1         = 16'h0001;
  localparam logic [15:0] EXT_V2_X2         = 16'h000c;
  localparam logic [15:0] EXT_V2_X4         = 16'h000e;
  localparam logic [15:0] EXT_V2_X8         = 16'h0012;
  localparam logic [15:0] EXT_P_V1_X1       = 16'h0064;
  localparam logic [15:0] EXT_P_V2_X2       = 16'h0070;
  localparam logic [15:0] EXT_P_V2_X4       = 16'h0072;
  localparam logic [15:0] EXT_P_V2_X8       = 16'h0076;
  // timing
  localparam int          CLK_KHZ           = 200000;
  localparam int          ERASE_TIME_MS     = 5000;
  localparam int          ERASE_CYCLES      = ERASE_TIME_MS * CLK_KHZ;
  localparam int          REFRESH_MIN_US    = 3500;
  localparam int          REFRESH_MAX_US    = 18000;
  localparam int          REFRESH_MIN_CYC   = REFRESH_MIN_US * (CLK_KHZ / 1000);
  localparam int          REFRESH_MAX_CYC   = REFRESH_MAX_US * (CLK_KHZ / 1000);
  // host wishbone register offsets
  localparam logic [3:0]  REG_PAR_ADDR      = 4'h0;
  localparam logic [3:0]  REG_PAR_DATA      = 4'h4;
  localparam logic [3:0]  REG_CTRL          = 4'h8;
  localparam logic [3:0]  REG_STATUS        = 4'hc;
  // control register bits
  localparam int          CTRL_WRITE_BIT    = 0;
  localparam int          CTRL_READ_BIT     = 1;
  localparam int          CTRL_LINK_BIT     = 2;
  localparam int          CTRL_DRST_BIT     = 3;
endpackage : drive_ctrl_pkg

/* File: include/drive_link_if.sv */
// link between fieldbus master controller and drive control block
`timescale 1ns/100ps
interface drive_link_if;
  logic        par_req;
  logic        par_we;
  logic [2:0]  par_addr;
  logic [15:0] par_wdata;
  logic        par_ack;
  logic        par_err;
  logic [15:0] par_rdata;
  logic        link_start;
  logic        refresh;
  logic        drive_reset;

  modport host (
    output par_req, par_we, par_addr, par_wdata, link_start, refresh, drive_reset,
    input  par_ack, par_err, par_rdata
  );
  modport device (
    input  par_req, par_we, par_addr, par_wdata, link_start, refresh, drive_reset,
    output par_ack, par_err, par_rdata
  );
endinterface : drive_link_if

/* File: hw/drive_lock_ctrl.sv */
// drive end: start lock gating, program flash clear and fieldbus setting
`timescale 1ns/100ps
module drive_lock_ctrl #(
  parameter int unsigned ERASE_CYCLES = drive_ctrl_pkg::ERASE_CYCLES,
  parameter int unsigned REFRESH_MAX  = drive_ctrl_pkg::REFRESH_MAX_CYC
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // link
  drive_link_if.device    link,
  // pins
  input  wire logic       program_run_key_signal_i,
  input  wire logic       forward_start_input_i,
  input  wire logic       reverse_start_input_i,
  input  wire logic       panel_fwd_start_i,
  input  wire logic       panel_rev_start_i,
  // program and drive stage
  input  wire logic       prog_fwd_start_i,
  input  wire logic       prog_rev_start_i,
  input  wire logic       motor_stopped_i,
  input  wire logic       program_load_i,
  input  wire logic       password_set_i,
  // outputs
  output logic            run_fwd_o,
  output logic            run_rev_o,
  output logic            decel_o,
  output logic            erase_busy_o,
  output logic            flash_erase_o,
  output logic            program_loaded_o,
  output logic            password_present_o,
  output logic            program_function_o,
  output logic            version2_o,
  output logic [1:0]      occupancy_o,
  output logic            link_alive_o
);

  typedef enum logic [3:0] {
    DRV_IDLE  = 4'b0001,
    DRV_FWD   = 4'b0010,
    DRV_REV   = 4'b0100,
    DRV_DECEL = 4'b1000
  } drv_state_t;

  typedef struct packed {
    logic        key_s1;
    logic        key_s2;
    logic        key_d;
    logic [3:0]  pin_s1;
    logic [3:0]  pin_s2;
    drv_state_t  state;
    logic [15:0] lock;
    logic [15:0] pfe;
    logic [15:0] ext_pend;
    logic        pfunc;
    logic        ver2;
    logic [1:0]  occ;
    logic        busy;
    logic [31:0] erase_cnt;
    logic        erase_go;
    logic        prog_ok;
    logic        pw;
    logic        ack;
    logic        err;
    logic [15:0] rdata;
    logic [31:0] wd_cnt;
    logic        alive;
  } dev_state_t;

  dev_state_t s_r;
  dev_state_t s_nxt;

  logic        key_run;
  logic        fwd_req;
  logic        rev_req;
  logic        start_ok;
  logic        operating;
  logic        wr;
  logic        ext_ok;

  always_comb begin
    key_run   = s_r.key_s2;
    fwd_req   = s_r.pin_s2[0] | s_r.pin_s2[2] | prog_fwd_start_i;
    rev_req   = s_r.pin_s2[1] | s_r.pin_s2[3] | prog_rev_start_i;
    start_ok  = (s_r.lock == drive_ctrl_pkg::LOCK_RESET) | key_run;
    operating = s_r.state != DRV_IDLE;
    wr        = link.par_req & ~s_r.ack & link.par_we;
    case (link.par_wdata)
      drive_ctrl_pkg::EXT_V1_LEGACY, drive_ctrl_pkg::EXT_V2_X1, drive_ctrl_pkg::EXT_V2_X2,
      drive_ctrl_pkg::EXT_V2_X4, drive_ctrl_pkg::EXT_V2_X8, drive_ctrl_pkg::EXT_P_V1_X1,
      drive_ctrl_pkg::EXT_P_V2_X2, drive_ctrl_pkg::EXT_P_V2_X4,
      drive_ctrl_pkg::EXT_P_V2_X8: ext_ok = 1'b1;
      default: ext_ok = 1'b0;
    endcase
  end

  always_comb begin
    s_nxt          = s_r;
    s_nxt.erase_go = 1'b0;
    s_nxt.key_s1   = program_run_key_signal_i;
    s_nxt.key_s2   = s_r.key_s1;
    s_nxt.key_d    = s_r.key_s2;
    s_nxt.pin_s1   = {panel_rev_start_i, panel_fwd_start_i, reverse_start_input_i, forward_start_input_i};
    s_nxt.pin_s2   = s_r.pin_s1;

    // drive start and stop
    case (s_r.state)
      DRV_IDLE: begin
        if (start_ok && fwd_req && !rev_req) begin
          s_nxt.state = DRV_FWD;
        end else if (start_ok && rev_req && !fwd_req) begin
          s_nxt.state = DRV_REV;
        end
      end
      DRV_FWD, DRV_REV: begin
        // key drop in mode 1 stops; mode 0 carries on
        if (s_r.lock != drive_ctrl_pkg::LOCK_RESET && s_r.key_d && !key_run) begin
          s_nxt.state = DRV_DECEL;
        end else if ((s_r.state == DRV_FWD) ? !fwd_req : !rev_req) begin
          s_nxt.state = DRV_DECEL;
        end
      end
      DRV_DECEL: begin
        if (motor_stopped_i) begin
          s_nxt.state = DRV_IDLE;
        end
      end
      default: s_nxt.state = DRV_IDLE;
    endcase

    // parameter access
    s_nxt.ack = link.par_req & ~s_r.ack;
    if (link.par_req && !s_r.ack) begin
      s_nxt.err   = 1'b0;
      s_nxt.rdata = 16'h0000;
      case (link.par_addr)
        drive_ctrl_pkg::PAR_LOCK_ADDR: begin
          if (wr) begin
            if (operating || link.par_wdata > drive_ctrl_pkg::LOCK_MAX) begin
              s_nxt.err = 1'b1;
            end else begin
              s_nxt.lock = link.par_wdata;
            end
          end
          s_nxt.rdata = s_r.lock;
        end
        drive_ctrl_pkg::PAR_ERASE_ADDR: begin
          if (wr) begin
            if (link.par_wdata > drive_ctrl_pkg::ERASE_MAX) begin
              s_nxt.err = 1'b1;
            end else if (link.par_wdata == drive_ctrl_pkg::ERASE_KEY && !s_r.busy
                         && s_r.pfe == drive_ctrl_pkg::PFE_RESET) begin
              s_nxt.busy      = 1'b1;
              s_nxt.erase_cnt = 32'h0000_0000;
              s_nxt.erase_go  = 1'b1;
            end
          end
          s_nxt.rdata = 16'h0000;
        end
        drive_ctrl_pkg::PAR_EXT_ADDR: begin
          if (wr) begin
            if (ext_ok) begin
              s_nxt.ext_pend = link.par_wdata;
            end else begin
              s_nxt.err = 1'b1;
            end
          end
          s_nxt.rdata = s_r.ext_pend;
        end
        drive_ctrl_pkg::PAR_PFE_ADDR: begin
          if (wr) begin
            if (link.par_wdata > 16'h0001 || s_r.busy) begin
              s_nxt.err = 1'b1;
            end else begin
              s_nxt.pfe = link.par_wdata;
            end
          end
          s_nxt.rdata = s_r.pfe;
        end
        default: s_nxt.err = 1'b1;
      endcase
    end

    // flash erase timing
    if (s_r.busy) begin
      s_nxt.erase_cnt = s_r.erase_cnt + 32'h0000_0001;
      if (s_r.erase_cnt == 32'(ERASE_CYCLES - 1)) begin
        s_nxt.busy    = 1'b0;
        s_nxt.pw      = 1'b0;
        s_nxt.prog_ok = 1'b0;
      end
    end else begin
      if (program_load_i) begin
        s_nxt.prog_ok = 1'b1;
      end
      if (password_set_i) begin
        s_nxt.pw = 1'b1;
      end
    end

    // setting takes effect on drive reset
    if (link.drive_reset) begin
      s_nxt.pfunc = s_r.ext_pend >= drive_ctrl_pkg::EXT_P_V1_X1;
      s_nxt.ver2  = s_r.ext_pend != drive_ctrl_pkg::EXT_V1_LEGACY
                    && s_r.ext_pend != drive_ctrl_pkg::EXT_P_V1_X1;
      case (s_r.ext_pend)
        drive_ctrl_pkg::EXT_V2_X2, drive_ctrl_pkg::EXT_P_V2_X2: s_nxt.occ = 2'h1;
        drive_ctrl_pkg::EXT_V2_X4, drive_ctrl_pkg::EXT_P_V2_X4: s_nxt.occ = 2'h2;
        drive_ctrl_pkg::EXT_V2_X8, drive_ctrl_pkg::EXT_P_V2_X8: s_nxt.occ = 2'h3;
        default: s_nxt.occ = 2'h0;
      endcase
    end

    // refresh watchdog
    if (!link.link_start || link.refresh) begin
      s_nxt.wd_cnt = 32'h0000_0000;
      s_nxt.alive  = link.link_start & link.refresh;
    end else if (s_r.wd_cnt >= 32'(REFRESH_MAX)) begin
      s_nxt.alive  = 1'b0;
    end else begin
      s_nxt.wd_cnt = s_r.wd_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r          <= '0;
      s_r.state    <= DRV_IDLE;
      s_r.lock     <= drive_ctrl_pkg::LOCK_RESET;
      s_r.pfe      <= drive_ctrl_pkg::PFE_RESET;
      s_r.ext_pend <= drive_ctrl_pkg::EXT_RESET;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    link.par_ack       = s_r.ack;
    link.par_err       = s_r.err;
    link.par_rdata     = s_r.rdata;
    run_fwd_o          = s_r.state == DRV_FWD;
    run_rev_o          = s_r.state == DRV_REV;
    decel_o            = s_r.state == DRV_DECEL;
    erase_busy_o       = s_r.busy;
    flash_erase_o      = s_r.erase_go;
    program_loaded_o   = s_r.prog_ok;
    password_present_o = s_r.pw;
    program_function_o = s_r.pfunc;
    version2_o         = s_r.ver2;
    occupancy_o        = s_r.occ;
    link_alive_o       = s_r.alive;
  end

endmodule : drive_lock_ctrl

/* File: hw/fieldbus_master_ctrl.sv */
// master end: wishbone registers, parameter requests and link refresh
`timescale 1ns/100ps
module fieldbus_master_ctrl #(
  parameter int unsigned REFRESH_CYCLES = drive_ctrl_pkg::REFRESH_MIN_CYC,
  parameter int unsigned GUARD_CYCLES   = drive_ctrl_pkg::ERASE_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // link
  drive_link_if.host       link
);

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [2:0]  addr;
    logic [15:0] data;
    logic        req;
    logic        we;
    logic        err;
    logic        link_on;
    logic        drst;
    logic        drst_pend;
    logic [31:0] guard;
    logic [31:0] rcnt;
    logic        refresh;
  } host_state_t;

  host_state_t s_r;
  host_state_t s_nxt;
  logic        acc;

  always_comb begin
    acc             = cyc_i & stb_i & ~s_r.ack;
    s_nxt           = s_r;
    s_nxt.ack       = acc;
    s_nxt.drst      = 1'b0;
    s_nxt.refresh   = 1'b0;
    if (acc) begin
      case (adr_i)
        drive_ctrl_pkg::REG_PAR_ADDR: s_nxt.dat = {29'h0, s_r.addr};
        drive_ctrl_pkg::REG_PAR_DATA: s_nxt.dat = {16'h0000, s_r.data};
        drive_ctrl_pkg::REG_STATUS:   s_nxt.dat = {27'h0, s_r.guard != 32'h0, s_r.drst_pend, s_r.link_on,
                                                   s_r.err, s_r.req};
        default:                      s_nxt.dat = 32'h0000_0000;
      endcase
      if (we_i && sel_i[0] && !s_r.req) begin
        case (adr_i)
          drive_ctrl_pkg::REG_PAR_ADDR: s_nxt.addr = dat_i[2:0];
          drive_ctrl_pkg::REG_PAR_DATA: begin
            if (sel_i[1]) begin
              s_nxt.data = dat_i[15:0];
            end
          end
          drive_ctrl_pkg::REG_CTRL: begin
            s_nxt.link_on = dat_i[drive_ctrl_pkg::CTRL_LINK_BIT];
            if (dat_i[drive_ctrl_pkg::CTRL_WRITE_BIT] || dat_i[drive_ctrl_pkg::CTRL_READ_BIT]) begin
              s_nxt.req = 1'b1;
              s_nxt.we  = dat_i[drive_ctrl_pkg::CTRL_WRITE_BIT];
              s_nxt.err = 1'b0;
            end
            if (dat_i[drive_ctrl_pkg::CTRL_DRST_BIT]) begin
              s_nxt.drst_pend = 1'b1;
            end
          end
          default: s_nxt.dat = s_r.dat;
        endcase
      end
    end
    // drive reset held off while an erase may be running
    if (s_r.guard != 32'h0000_0000) begin
      s_nxt.guard = s_r.guard - 32'h0000_0001;
    end else if (s_r.drst_pend) begin
      s_nxt.drst_pend = 1'b0;
      s_nxt.drst      = 1'b1;
    end
    // request completion last: a fresh key write re-arms the guard
    if (s_r.req && link.par_ack) begin
      s_nxt.req = 1'b0;
      s_nxt.err = link.par_err;
      if (!s_r.we) begin
        s_nxt.data = link.par_rdata;
      end
      if (s_r.we && !link.par_err && s_r.addr == drive_ctrl_pkg::PAR_ERASE_ADDR
          && s_r.data == drive_ctrl_pkg::ERASE_KEY) begin
        s_nxt.guard = 32'(GUARD_CYCLES);
      end
    end
    // free-running refresh once link started
    if (!s_r.link_on || s_r.rcnt == 32'(REFRESH_CYCLES - 1)) begin
      s_nxt.rcnt    = 32'h0000_0000;
      s_nxt.refresh = s_r.link_on;
    end else begin
      s_nxt.rcnt = s_r.rcnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    ack_o            = s_r.ack;
    dat_o            = s_r.dat;
    link.par_req     = s_r.req;
    link.par_we      = s_r.we;
    link.par_addr    = s_r.addr;
    link.par_wdata   = s_r.data;
    link.link_start  = s_r.link_on;
    link.refresh     = s_r.refresh;
    link.drive_reset = s_r.drst;
  end

endmodule : fieldbus_master_ctrl

/* File: bench/link_assertions.sv */
// link checker: parameter answers, refresh pulses and reset guard
`timescale 1ns/100ps
module link_assertions #(
  parameter int REFRESH = 20,
  parameter int GUARD   = 50
) (
  // clock, reset and link signals
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        par_req,
  input wire logic        par_we,
  input wire logic [2:0]  par_addr,
  input wire logic [15:0] par_wdata,
  input wire logic        par_ack,
  input wire logic        par_err,
  input wire logic [15:0] par_rdata,
  input wire logic        link_start,
  input wire logic        refresh,
  input wire logic        drive_reset
);
  localparam int PER_MAX = REFRESH + 1;
  int  guard_r;
  wire wack = par_ack && par_we;
  wire ekey = wack && par_addr == drive_ctrl_pkg::PAR_ERASE_ADDR && par_wdata == drive_ctrl_pkg::ERASE_KEY;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  // guard loaded on the key answer, same edge as the host's, but 3 cycles shorter
  always_ff @(posedge clk_i) begin
    if (rst_i) guard_r <= 0;
    else if (ekey) guard_r <= GUARD - 3;
    else if (guard_r != 0) guard_r <= guard_r - 1;
  end
  a_lock_range: assert property (wack && par_addr == 3'h0 && par_wdata > 16'h0001 |-> par_err)
    else $error("lock value out of range accepted");
  a_erase_range: assert property (wack && par_addr == 3'h1 && par_wdata > 16'h270f |-> par_err)
    else $error("erase key out of range accepted");
  a_erase_reads_zero: assert property (par_ack && !par_we && par_addr == 3'h1 |-> par_rdata == 16'h0000)
    else $error("erase key read not zero");
  a_prog_refused: assert property (par_ack && par_addr[2] |-> par_err)
    else $error("program area access accepted");
  a_ext_list: assert property (wack && par_addr == 3'h2 && !(par_wdata inside {16'h0000, 16'h0001, 16'h000c,
    16'h000e, 16'h0012, 16'h0064, 16'h0070, 16'h0072, 16'h0076}) |-> par_err) else $error("bad code accepted");
  a_refresh_linked: assert property (refresh |-> link_start || $past(link_start))
    else $error("refresh without link start");
  a_refresh_period: assert property (link_start && refresh |-> ##[1:PER_MAX] (refresh || !link_start))
    else $error("refresh gap too long");
  a_refresh_spacing: assert property (refresh |=> !refresh [*8])
    else $error("refresh too frequent");
  a_reset_guard: assert property (guard_r != 0 |-> !drive_reset)
    else $error("drive reset during erase guard");
  c_key: cover property (ekey);
  c_drst: cover property (drive_reset);
  c_err: cover property (par_ack && par_err);
endmodule : link_assertions

/* File: bench/testbench.sv */
// self-checking bench: both ends joined, wishbone and pins driven
`timescale 1ns/100ps
`define CHK(n, g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  typedef struct {string n; logic [31:0] e; logic [31:0] m; bit p;} note_t;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        cyc = 0, stb = 0, we = 0, ack, rchk = 0, pchk = 0, lnk = 0;
  logic [3:0]  adr = 0;
  logic [31:0] dwr = 0, rd, last;
  logic        key = 0, fwd = 0, rev = 0, pfwd = 0, gfwd = 0, stop = 0, load = 0, pwd = 0;
  logic        prev = 0, grev = 0, hce = 1, dce = 1;
  logic [3:0]  sel = 4'hf, n_ers = 4'h0;
  localparam int RCYC = 20, GCYC = 50, ECYC = 50, RMAX = 40;
  logic        rf, rr, dc, bsy, ers, ldd, pwp, pfn, v2, alive;
  logic [1:0]  occ;
  logic [11:0] pins;
  note_t       q[$], t;
  int          n_mismatch = 0, n_compared = 0, v;
  logic [15:0] codes[9] = '{16'h0001, 16'h000c, 16'h000e, 16'h0012, 16'h0064, 16'h0070, 16'h0072, 16'h0076, 16'h0000};
  logic [11:0] expv[9] = '{12'h100, 12'h300, 12'h500, 12'h700, 12'h080, 12'h380, 12'h580, 12'h780, 12'h000};
  assign pins = {alive, occ, v2, pfn, pwp, ldd, ers, bsy, dc, rr, rf};
  always #2.5 clk_i = ~clk_i;
  drive_link_if link_w ();
  fieldbus_master_ctrl #(.REFRESH_CYCLES(RCYC), .GUARD_CYCLES(GCYC)) u_fieldbus_master_ctrl (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(hce), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dwr),
    .dat_o(rd), .ack_o(ack), .link(link_w));
  drive_lock_ctrl #(.ERASE_CYCLES(ECYC), .REFRESH_MAX(RMAX)) u_drive_lock_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(dce), .link(link_w), .program_run_key_signal_i(key), .forward_start_input_i(fwd),
    .reverse_start_input_i(rev), .panel_fwd_start_i(pfwd), .panel_rev_start_i(prev), .prog_fwd_start_i(gfwd),
    .prog_rev_start_i(grev), .motor_stopped_i(stop), .program_load_i(load), .password_set_i(pwd),
    .run_fwd_o(rf), .run_rev_o(rr), .decel_o(dc), .erase_busy_o(bsy), .flash_erase_o(ers), .program_loaded_o(ldd),
    .password_present_o(pwp), .program_function_o(pfn), .version2_o(v2), .occupancy_o(occ), .link_alive_o(alive));
  link_assertions #(.REFRESH(RCYC), .GUARD(GCYC)) u_link_assertions (.clk_i(clk_i), .rst_i(rst_i), .ce_i(hce & dce),
    .par_req(link_w.par_req), .par_we(link_w.par_we), .par_addr(link_w.par_addr), .par_wdata(link_w.par_wdata),
    .par_ack(link_w.par_ack), .par_err(link_w.par_err), .par_rdata(link_w.par_rdata),
    .link_start(link_w.link_start), .refresh(link_w.refresh), .drive_reset(link_w.drive_reset));
  // erase start pulses, counted so a one-cycle pulse is not missed
  always @(posedge clk_i) begin
    if (ers === 1'b1) n_ers <= n_ers + 4'h1;
  end
  // oldest note against the result that just appeared
  always @(posedge clk_i) begin
    if ((ack === 1'b1 && rchk) || pchk) begin
      t = q.pop_front();
      `CHK(t.n, (t.p ? {16'h0, n_ers, pins} : rd) & t.m, t.e)
    end
  end
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic c);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dwr <= d;
    rchk <= c;
    do @(posedge clk_i); while (ack !== 1'b1);
    last = rd;
    cyc <= 0;
    stb <= 0;
    rchk <= 0;
    @(posedge clk_i);
  endtask : wb
  task rx(input string n, input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{n, e, m, 0});
    wb(0, a, 0, 1);
  endtask : rx
  task pin(input string n, input logic [11:0] e, input logic [11:0] m);
    repeat (8) @(posedge clk_i);
    q.push_back('{n, {20'h0, e}, {20'h0, m}, 1});
    pchk <= 1;
    @(posedge clk_i);
    pchk <= 0;
  endtask : pin
  task ctrl(input logic [3:0] c);
    wb(1, drive_ctrl_pkg::REG_CTRL, {28'h0, c | {1'b0, lnk, 2'b0}}, 0);
    do wb(0, drive_ctrl_pkg::REG_STATUS, 0, 0); while (last[0] !== 1'b0 || last[3] !== 1'b0);
  endtask : ctrl
  task pw(input logic [2:0] a, input logic [15:0] d, input logic e, input string n);
    wb(1, drive_ctrl_pkg::REG_PAR_ADDR, {29'h0, a}, 0);
    wb(1, drive_ctrl_pkg::REG_PAR_DATA, {16'h0, d}, 0);
    ctrl(4'h1);
    rx(n, drive_ctrl_pkg::REG_STATUS, {30'h0, e, 1'b0}, 32'h2);
  endtask : pw
  task pr(input logic [2:0] a, input logic [15:0] e, input string n);
    wb(1, drive_ctrl_pkg::REG_PAR_ADDR, {29'h0, a}, 0);
    ctrl(4'h2);
    rx(n, drive_ctrl_pkg::REG_PAR_DATA, {16'h0, e}, 32'hffff);
  endtask : pr
  task test_done;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
  initial begin
    v = $urandom(74);
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    pr(drive_ctrl_pkg::PAR_LOCK_ADDR, 16'h0, "lock");
    pr(drive_ctrl_pkg::PAR_EXT_ADDR, 16'h0, "ext");
    pin("pins", 12'h000, 12'hfff);
    wb(1, drive_ctrl_pkg::REG_PAR_DATA, 32'h0000_1234, 0);
    sel <= 4'h1;
    wb(1, drive_ctrl_pkg::REG_PAR_DATA, 32'h0000_abcd, 0);
    sel <= 4'hf;
    rx("sel_low", drive_ctrl_pkg::REG_PAR_DATA, 32'h0000_1234, 32'hffff);
    $display("test reset done");
    fwd <= 1;
    key <= 1;
    pin("run_fwd", 12'h1, 12'h7);
    key <= 0;
    pin("still_fwd", 12'h1, 12'h7);
    pw(drive_ctrl_pkg::PAR_LOCK_ADDR, 16'h1, 1, "lock_running");
    fwd <= 0;
    pin("decel", 12'h4, 12'h7);
    stop <= 1;
    pin("idle", 12'h0, 12'h7);
    stop <= 0;
    pw(drive_ctrl_pkg::PAR_LOCK_ADDR, 16'h2, 1, "lock_range");
    pw(drive_ctrl_pkg::PAR_LOCK_ADDR, 16'h1, 0, "lock_set");
    $display("test mode0 done");
    for (int i = 0; i < 5; i++) begin
      {grev, prev, gfwd, pfwd, rev} <= 5'b00001 << i;
      pin("blocked", 12'h0, 12'h7);
    end
    {grev, prev, gfwd, pfwd, rev} <= 5'b00001;
    key <= 1;
    pin("run_rev", 12'h2, 12'h7);
    key <= 0;
    pin("key_decel", 12'h4, 12'h7);
    stop <= 1;
    rev <= 0;
    pin("stopped", 12'h0, 12'h7);
    stop <= 0;
    $display("test mode1 done");
    pw(drive_ctrl_pkg::PAR_PFE_ADDR, 16'h1, 0, "pfe_on");
    pw(drive_ctrl_pkg::PAR_ERASE_ADDR, drive_ctrl_pkg::ERASE_KEY, 0, "key_pfe");
    pin("no_erase", 12'h0, 12'h8);
    pw(drive_ctrl_pkg::PAR_PFE_ADDR, 16'h0, 0, "pfe_off");
    pw(drive_ctrl_pkg::PAR_ERASE_ADDR, 16'h2710, 1, "key_range");
    load <= 1;
    pwd <= 1;
    @(posedge clk_i);
    load <= 0;
    pwd <= 0;
    v = $urandom % 10000;
    if (v == 9696) v = 1;
    pw(drive_ctrl_pkg::PAR_ERASE_ADDR, v[15:0], 0, "key_other");
    pin("kept", 12'h060, 12'h068);
    pr(drive_ctrl_pkg::PAR_ERASE_ADDR, 16'h0, "key_read");
    pw(drive_ctrl_pkg::PAR_ERASE_ADDR, drive_ctrl_pkg::ERASE_KEY, 0, "key");
    pin("busy", 12'h068, 12'h068);
    pw(drive_ctrl_pkg::PAR_ERASE_ADDR, drive_ctrl_pkg::ERASE_KEY, 0, "key_again");
    repeat (12) @(posedge clk_i);
    pin("erased", 12'h000, 12'h068);
    @(posedge clk_i);
    q.push_back('{"erase_pulses", 32'h0000_1000, 32'h0000_f000, 1'b1});
    pchk <= 1;
    @(posedge clk_i);
    pchk <= 0;
    $display("test erase done");
    foreach (codes[i]) begin
      pw(drive_ctrl_pkg::PAR_EXT_ADDR, codes[i], 0, "ext_set");
      pin("ext_held", i == 0 ? 12'h0 : expv[i - 1], 12'h780);
      ctrl(4'h8);
      pin("ext_applied", expv[i], 12'h780);
    end
    pw(drive_ctrl_pkg::PAR_EXT_ADDR, 16'h0002, 1, "ext_bad");
    pw(drive_ctrl_pkg::PAR_PROG_ADDR, 16'h0, 1, "prog");
    $display("test setting done");
    lnk = 1;
    ctrl(4'h0);
    repeat (30) @(posedge clk_i);
    pin("alive", 12'h800, 12'h800);
    dce <= 0;
    lnk = 0;
    ctrl(4'h0);
    pin("frozen", 12'h800, 12'h800);
    dce <= 1;
    pin("dead", 12'h000, 12'h800);
    lnk = 1;
    ctrl(4'h0);
    do @(posedge clk_i); while (link_w.refresh !== 1'b1);
    hce <= 0;
    repeat (45) @(posedge clk_i);
    pin("gap", 12'h000, 12'h800);
    hce <= 1;
    lnk = 0;
    ctrl(4'h0);
    $display("test link done");
    test_done();
  end
endmodule : testbench
